// file: rtl/scmd_pkg.sv
package scmd_pkg;
  // register map, byte addresses on the bus
  localparam logic [7:0] SCMD_CTRL_OFS = 8'h00;
  localparam logic [7:0] SCMD_STAT_OFS = 8'h04;
  // control fields
  localparam int SCMD_CTRL_MUX_EN = 0;
  localparam int SCMD_CTRL_DEMUX_EN = 1;
  localparam int SCMD_CTRL_W = 2;
  localparam logic [1:0] SCMD_CTRL_RST = 2'h3;
  // status fields
  localparam int SCMD_STAT_GRANT_LSB = 0;
  localparam int SCMD_STAT_GRANT_W = 4;
  localparam int SCMD_STAT_ACTIVE = 4;
  localparam int SCMD_STAT_MO_VALID = 5;
  localparam int SCMD_STAT_DEMUX_BUSY = 6;
  // bus encodings
  localparam logic [1:0] SCMD_HTRANS_NONSEQ = 2'h2;
  localparam logic SCMD_HRESP_OKAY = 1'b0;
  // build-time limits
  localparam int SCMD_PORTS_MIN = 2;
  localparam int SCMD_PORTS_MAX = 16;
  localparam int SCMD_SYM_MIN = 1;
  localparam int SCMD_SYM_MAX = 32;
  localparam int SCMD_CHW_MAX = 31;
  // arbiter states
  typedef enum logic {ARB_PICK, ARB_SEND} scmd_arb_t;
endpackage

// file: rtl/scmd_demux.sv
`timescale 1ns/1ps
`default_nettype none
module scmd_demux #(
  parameter int NUM_OUT = 2,
  parameter int BPS = 8,
  parameter int SPB = 1,
  parameter bit USE_PKT = 1'b0,
  parameter int CH_W = 4,
  parameter int ERR_W = 0,
  parameter bit HI_SEL = 1'b0,
  localparam int DW = BPS * SPB,
  localparam int EW = (ERR_W > 0) ? ERR_W : 1,
  localparam int MW = (SPB > 1) ? $clog2(SPB) : 1,
  localparam int SEL_W = $clog2(NUM_OUT),
  localparam int OCW = (CH_W > SEL_W) ? CH_W - SEL_W : 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control and status
  input wire logic enable,
  output logic busy,
  // input stream
  input wire logic di_valid,
  output logic di_ready,
  input wire logic [DW-1:0] di_data,
  input wire logic [CH_W-1:0] di_ch,
  input wire logic [EW-1:0] di_err,
  input wire logic di_sop,
  input wire logic di_eop,
  input wire logic [MW-1:0] di_empty,
  // output streams, shared payload
  output logic [NUM_OUT-1:0] do_valid,
  input wire logic [NUM_OUT-1:0] do_ready,
  output logic [DW-1:0] do_data,
  output logic [OCW-1:0] do_ch,
  output logic [EW-1:0] do_err,
  output logic do_sop,
  output logic do_eop,
  output logic [MW-1:0] do_empty
);
  import scmd_pkg::*;

  if (NUM_OUT < SCMD_PORTS_MIN || NUM_OUT > SCMD_PORTS_MAX) begin : g_bad_num
    $error("output port count out of range");
  end

  logic [NUM_OUT-1:0] do_valid_reg;
  logic [SEL_W-1:0] sel_reg;
  logic [DW-1:0] data_reg;
  logic [OCW-1:0] ch_reg;
  logic [EW-1:0] err_reg;
  logic sop_reg;
  logic eop_reg;
  logic [MW-1:0] empty_reg;
  logic [NUM_OUT-1:0] valid_next;

  // one slot only: beats leave in the order they came
  wire slot_v = |do_valid_reg;
  wire slot_free = !slot_v || do_ready[sel_reg];
  assign di_ready = enable && slot_free;
  wire accept = di_valid && di_ready;

  wire [SEL_W-1:0] sel_raw = HI_SEL ? di_ch[CH_W-1 -: SEL_W] : di_ch[SEL_W-1:0];
  // codes past the last port land on it rather than vanish
  wire [SEL_W-1:0] sel_in = (sel_raw > SEL_W'(NUM_OUT - 1)) ? SEL_W'(NUM_OUT - 1) : sel_raw;
  wire [CH_W-1:0] ch_shift = di_ch >> SEL_W;
  wire [OCW-1:0] ch_pass = HI_SEL ? OCW'(di_ch) : OCW'(ch_shift);

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_vld
    assign valid_next[i] = accept && (sel_in == SEL_W'(i));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      do_valid_reg <= '0;
      sel_reg <= '0;
    end else if (slot_free) begin
      do_valid_reg <= valid_next;
      sel_reg <= accept ? sel_in : sel_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= '0;
      ch_reg <= '0;
      err_reg <= '0;
      sop_reg <= 1'b0;
      eop_reg <= 1'b0;
      empty_reg <= '0;
    end else if (accept) begin
      data_reg <= di_data;
      ch_reg <= ch_pass;
      err_reg <= (ERR_W > 0) ? di_err : '0;
      sop_reg <= USE_PKT && di_sop;
      eop_reg <= USE_PKT && di_eop;
      empty_reg <= USE_PKT ? di_empty : '0;
    end
  end

  assign do_valid = do_valid_reg;
  assign do_data = data_reg;
  assign do_ch = ch_reg;
  assign do_err = err_reg;
  assign do_sop = sop_reg;
  assign do_eop = eop_reg;
  assign do_empty = empty_reg;
  assign busy = slot_v;

  idle_others_a: assert property (@(posedge hclk) disable iff (!hresetn) $onehot0(do_valid_reg))
    else $error("more than one demux output valid");
  route_port_a: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |=> do_valid_reg[sel_reg] && (ch_reg == $past(ch_pass)))
    else $error("beat sent to wrong output");
  demux_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (slot_v && !do_ready[sel_reg]) |=> (do_valid_reg == $past(do_valid_reg)) && $stable(data_reg))
    else $error("demux output changed while stalled");
endmodule
`default_nettype wire

// file: rtl/scmd_top.sv
`timescale 1ns/1ps
`default_nettype none
module scmd_top #(
  parameter int NUM_IN = 4,
  parameter int NUM_OUT = 2,
  parameter int BPS = 8,
  parameter int SPB = 1,
  parameter bit USE_PKT = 1'b0,
  parameter int CH_W = 4,
  parameter int DCH_W = 4,
  parameter int ERR_W = 0,
  parameter int SCHED = 2,
  parameter bit HI_SRC = 1'b1,
  parameter bit HI_SEL = 1'b0,
  localparam int DW = BPS * SPB,
  localparam int CWI = (CH_W > 0) ? CH_W : 1,
  localparam int EW = (ERR_W > 0) ? ERR_W : 1,
  localparam int MW = (SPB > 1) ? $clog2(SPB) : 1,
  localparam int SRC_W = $clog2(NUM_IN),
  localparam int OCW = CH_W + SRC_W,
  localparam int DSEL_W = $clog2(NUM_OUT),
  localparam int DOCW = (DCH_W > DSEL_W) ? DCH_W - DSEL_W : 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // mux input streams, port i in slice i
  input wire logic [NUM_IN-1:0] mi_valid,
  output logic [NUM_IN-1:0] mi_ready,
  input wire logic [NUM_IN*DW-1:0] mi_data,
  input wire logic [NUM_IN*CWI-1:0] mi_ch,
  input wire logic [NUM_IN*EW-1:0] mi_err,
  input wire logic [NUM_IN-1:0] mi_sop,
  input wire logic [NUM_IN-1:0] mi_eop,
  input wire logic [NUM_IN*MW-1:0] mi_empty,
  // mux output stream
  output logic mo_valid,
  input wire logic mo_ready,
  output logic [DW-1:0] mo_data,
  output logic [OCW-1:0] mo_ch,
  output logic [EW-1:0] mo_err,
  output logic mo_sop,
  output logic mo_eop,
  output logic [MW-1:0] mo_empty,
  // demux input stream
  input wire logic di_valid,
  output logic di_ready,
  input wire logic [DW-1:0] di_data,
  input wire logic [DCH_W-1:0] di_ch,
  input wire logic [EW-1:0] di_err,
  input wire logic di_sop,
  input wire logic di_eop,
  input wire logic [MW-1:0] di_empty,
  // demux output streams
  output logic [NUM_OUT-1:0] do_valid,
  input wire logic [NUM_OUT-1:0] do_ready,
  output logic [DW-1:0] do_data,
  output logic [DOCW-1:0] do_ch,
  output logic [EW-1:0] do_err,
  output logic do_sop,
  output logic do_eop,
  output logic [MW-1:0] do_empty
);
  import scmd_pkg::*;

  if (NUM_IN < SCMD_PORTS_MIN || NUM_IN > SCMD_PORTS_MAX) begin : g_bad_in
    $error("input port count out of range");
  end
  if (BPS < SCMD_SYM_MIN || BPS > SCMD_SYM_MAX) begin : g_bad_bps
    $error("bits per symbol out of range");
  end
  if (SPB < SCMD_SYM_MIN || SPB > SCMD_SYM_MAX) begin : g_bad_spb
    $error("symbols per beat out of range");
  end
  if (CH_W < 0 || CH_W > SCMD_CHW_MAX) begin : g_bad_ch
    $error("input channel width out of range");
  end

  // register bus slave
  logic [SCMD_CTRL_W-1:0] ctrl_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic [31:0] rd_mux;

  wire ahb_req = hsel && hready && htrans[1];
  wire ctrl_wr = wr_pend_reg && (addr_reg == SCMD_CTRL_OFS);
  // a read right behind a control write sees the new value
  wire [SCMD_CTRL_W-1:0] ctrl_now = ctrl_wr ? hwdata[SCMD_CTRL_W-1:0] : ctrl_reg;
  wire mux_en = ctrl_reg[SCMD_CTRL_MUX_EN];
  wire demux_en = ctrl_reg[SCMD_CTRL_DEMUX_EN];

  // mux state
  scmd_arb_t state_reg;
  scmd_arb_t state_next;
  logic [SRC_W-1:0] grant_reg;
  logic [SRC_W-1:0] grant_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [SRC_W-1:0] pick;
  logic pick_found;
  logic demux_busy;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == SCMD_CTRL_OFS) begin
      rd_mux[SCMD_CTRL_W-1:0] = ctrl_now;
    end else if (haddr[7:0] == SCMD_STAT_OFS) begin
      rd_mux[SCMD_STAT_GRANT_LSB +: SCMD_STAT_GRANT_W] = SCMD_STAT_GRANT_W'(grant_reg);
      rd_mux[SCMD_STAT_ACTIVE] = (state_reg == ARB_SEND);
      rd_mux[SCMD_STAT_MO_VALID] = mo_valid;
      rd_mux[SCMD_STAT_DEMUX_BUSY] = demux_busy;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= SCMD_CTRL_RST;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_now;
      wr_pend_reg <= ahb_req && hwrite;
      addr_reg <= ahb_req ? haddr[7:0] : addr_reg;
      hrdata_reg <= (ahb_req && !hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout_reg <= 1'b1;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = SCMD_HRESP_OKAY;
  assign hrdata = hrdata_reg;

  // unpack the input slices
  logic [DW-1:0] in_d [NUM_IN];
  logic [CWI-1:0] in_c [NUM_IN];
  logic [EW-1:0] in_e [NUM_IN];
  logic [MW-1:0] in_m [NUM_IN];
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    assign in_d[i] = mi_data[i*DW +: DW];
    assign in_c[i] = mi_ch[i*CWI +: CWI];
    assign in_e[i] = mi_err[i*EW +: EW];
    assign in_m[i] = mi_empty[i*MW +: MW];
  end

  // round robin search starts one past the last grant
  always_comb begin
    pick = grant_reg;
    pick_found = 1'b0;
    for (int k = NUM_IN; k >= 1; k--) begin
      if (mi_valid[(int'(grant_reg) + k) % NUM_IN]) begin
        pick = SRC_W'((int'(grant_reg) + k) % NUM_IN);
        pick_found = 1'b1;
      end
    end
  end

  // output slot loads when empty or drained this cycle
  logic mo_valid_reg;
  wire load = !mo_valid_reg || mo_ready;
  wire sending = (state_reg == ARB_SEND);
  wire take = sending && load && mi_valid[grant_reg];
  wire eop_g = USE_PKT && mi_eop[grant_reg];

  for (genvar i = 0; i < NUM_IN; i++) begin : g_rdy
    assign mi_ready[i] = sending && load && (grant_reg == SRC_W'(i));
  end

  always_comb begin
    state_next = state_reg;
    grant_next = grant_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ARB_PICK: begin
        if (mux_en && pick_found) begin
          state_next = ARB_SEND;
          grant_next = pick;
          cnt_next = 8'h00;
        end
      end
      ARB_SEND: begin
        if (take) begin
          if (cnt_reg == 8'(SCHED - 1) || eop_g) begin
            state_next = ARB_PICK;
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end else if (load) begin
          state_next = ARB_PICK;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ARB_PICK;
      grant_reg <= '0;
      cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      grant_reg <= grant_next;
      cnt_reg <= cnt_next;
    end
  end

  // source index joins the channel field
  logic [OCW-1:0] och_next;
  if (CH_W == 0) begin : g_och_none
    assign och_next = grant_reg;
  end else if (HI_SRC) begin : g_och_hi
    assign och_next = {grant_reg, in_c[grant_reg]};
  end else begin : g_och_lo
    assign och_next = {in_c[grant_reg], grant_reg};
  end

  logic [DW-1:0] mo_data_reg;
  logic [OCW-1:0] mo_ch_reg;
  logic [EW-1:0] mo_err_reg;
  logic mo_sop_reg;
  logic mo_eop_reg;
  logic [MW-1:0] mo_empty_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mo_valid_reg <= 1'b0;
    end else if (load) begin
      mo_valid_reg <= take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mo_data_reg <= '0;
      mo_ch_reg <= '0;
      mo_err_reg <= '0;
      mo_sop_reg <= 1'b0;
      mo_eop_reg <= 1'b0;
      mo_empty_reg <= '0;
    end else if (take) begin
      mo_data_reg <= in_d[grant_reg];
      mo_ch_reg <= och_next;
      mo_err_reg <= (ERR_W > 0) ? in_e[grant_reg] : '0;
      mo_sop_reg <= USE_PKT && mi_sop[grant_reg];
      mo_eop_reg <= eop_g;
      mo_empty_reg <= USE_PKT ? in_m[grant_reg] : '0;
    end
  end

  assign mo_valid = mo_valid_reg;
  assign mo_data = mo_data_reg;
  assign mo_ch = mo_ch_reg;
  assign mo_err = mo_err_reg;
  assign mo_sop = mo_sop_reg;
  assign mo_eop = mo_eop_reg;
  assign mo_empty = mo_empty_reg;

  scmd_demux #(
    .NUM_OUT(NUM_OUT),
    .BPS(BPS),
    .SPB(SPB),
    .USE_PKT(USE_PKT),
    .CH_W(DCH_W),
    .ERR_W(ERR_W),
    .HI_SEL(HI_SEL)
  ) u_demux (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(demux_en),
    .busy(demux_busy),
    .di_valid(di_valid),
    .di_ready(di_ready),
    .di_data(di_data),
    .di_ch(di_ch),
    .di_err(di_err),
    .di_sop(di_sop),
    .di_eop(di_eop),
    .di_empty(di_empty),
    .do_valid(do_valid),
    .do_ready(do_ready),
    .do_data(do_data),
    .do_ch(do_ch),
    .do_err(do_err),
    .do_sop(do_sop),
    .do_eop(do_eop),
    .do_empty(do_empty)
  );

  one_grant_a: assert property (@(posedge hclk) disable iff (!hresetn) $onehot0(mi_ready))
    else $error("more than one input ready");
  src_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> mo_valid_reg && (mo_ch_reg == $past(och_next)))
    else $error("output channel lost source index");
  sched_limit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && cnt_reg == 8'(SCHED - 1)) |=> (state_reg == ARB_PICK) && (mi_ready == '0))
    else $error("grant kept past scheduling size");
  early_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sending && load && !mi_valid[grant_reg]) |=> state_reg == ARB_PICK)
    else $error("grant kept after valid dropped");
  eop_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && eop_g) |=> !sending && (mi_ready == '0))
    else $error("grant kept after packet end");
  mux_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mo_valid_reg && !mo_ready) |=> mo_valid_reg && $stable(mo_data_reg) && $stable(mo_ch_reg))
    else $error("mux output changed while stalled");
  pick_next_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == ARB_PICK && mux_en && pick_found) |=> sending && (grant_reg == $past(pick)))
    else $error("grant did not go to chosen input");
  read_ctrl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ahb_req && !hwrite && haddr[7:0] == SCMD_CTRL_OFS) |=> hrdata_reg[SCMD_CTRL_W-1:0] == ctrl_reg)
    else $error("control read back wrong");
endmodule
`default_nettype wire

// file: sim/scmd_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module scmd_sink_model #(
  parameter int N = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // stall mode
  input wire logic slow,
  // handshake
  output logic [N-1:0] ready
);
  logic [1:0] cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  // ready ignores valid, so a stalled beat must be held by the sender
  always_comb begin
    for (int k = 0; k < N; k++) begin
      ready[k] = !slow || (cnt_reg != 2'(k));
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_stream_channel_mux_demux.sv
`timescale 1ns/1ps
`default_nettype none
module tb_stream_channel_mux_demux;
  import scmd_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] mi_valid, mi_ready, mi_err, mi_sop, mi_eop, mi_empty, mi_ready2;
  logic [31:0] mi_data;
  logic [15:0] mi_ch;
  logic mo_valid, mo_ready, mo_err, mo_sop, mo_eop, mo_empty;
  logic [7:0] mo_data, di_data, do_data;
  logic [5:0] mo_ch;
  logic di_valid, di_ready, di_err, di_sop, di_eop, di_empty, do_err, do_sop, do_eop, do_empty, mo_valid2;
  logic [3:0] di_ch;
  logic [1:0] do_valid, do_ready;
  logic [2:0] do_ch;
  int mismatches = 0;
  int n_tests = 0;
  int n_hi = 0;
  logic [17:0] mq[$], dq[$], emq[$], edq[$];
  logic [15:0] srcq[4][$];
  logic [15:0] dsrcq[$];
  // second build: source bits low, output chosen by high channel bits
  logic [7:0] mo_data2, do_data2;
  logic [5:0] mo_ch2;
  logic [1:0] do_valid2;
  logic [2:0] do_ch2;
  // it sees each beat only once the first build takes it
  wire di_take = di_valid && di_ready;
  assign hready = hreadyout;
  scmd_top #(.NUM_IN(4), .NUM_OUT(2), .BPS(8), .SPB(1), .USE_PKT(1'b1), .CH_W(4), .DCH_W(4), .ERR_W(1),
    .SCHED(2), .HI_SRC(1'b1), .HI_SEL(1'b0)) u_scmd_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mi_valid(mi_valid), .mi_ready(mi_ready), .mi_data(mi_data), .mi_ch(mi_ch), .mi_err(mi_err),
    .mi_sop(mi_sop), .mi_eop(mi_eop), .mi_empty(mi_empty), .mo_valid(mo_valid), .mo_ready(mo_ready),
    .mo_data(mo_data), .mo_ch(mo_ch), .mo_err(mo_err), .mo_sop(mo_sop), .mo_eop(mo_eop), .mo_empty(mo_empty),
    .di_valid(di_valid), .di_ready(di_ready), .di_data(di_data), .di_ch(di_ch), .di_err(di_err),
    .di_sop(di_sop), .di_eop(di_eop), .di_empty(di_empty), .do_valid(do_valid), .do_ready(do_ready),
    .do_data(do_data), .do_ch(do_ch), .do_err(do_err), .do_sop(do_sop), .do_eop(do_eop), .do_empty(do_empty)
  );
  scmd_top #(.NUM_IN(4), .NUM_OUT(2), .BPS(8), .SPB(1), .USE_PKT(1'b1), .CH_W(4), .DCH_W(4), .ERR_W(1),
    .SCHED(2), .HI_SRC(1'b0), .HI_SEL(1'b1)) u_scmd_top_alt (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(), .hresp(), .hrdata(),
    .mi_valid(mi_valid), .mi_ready(mi_ready2), .mi_data(mi_data), .mi_ch(mi_ch), .mi_err(mi_err),
    .mi_sop(mi_sop), .mi_eop(mi_eop), .mi_empty(mi_empty), .mo_valid(mo_valid2), .mo_ready(mo_ready),
    .mo_data(mo_data2), .mo_ch(mo_ch2), .mo_err(), .mo_sop(), .mo_eop(), .mo_empty(),
    .di_valid(di_take), .di_ready(), .di_data(di_data), .di_ch(di_ch), .di_err(di_err),
    .di_sop(di_sop), .di_eop(di_eop), .di_empty(di_empty), .do_valid(do_valid2), .do_ready(2'h3),
    .do_data(do_data2), .do_ch(do_ch2), .do_err(), .do_sop(), .do_eop(), .do_empty()
  );
  scmd_sink_model #(.N(1)) u_mo_sink (.hclk(hclk), .hresetn(hresetn), .slow(slow), .ready(mo_ready));
  scmd_sink_model #(.N(2)) u_do_sink (.hclk(hclk), .hresetn(hresetn), .slow(slow), .ready(do_ready));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task final_report();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task tmo(input int k);
    if (k >= 3000) begin
      fail("wait timed out");
      final_report();
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail($sformatf("%s got %h exp %h", m, got, exp));
    end
  endtask
  // one bus phase: hold until hready seen high at a rising edge
  task hwait(output logic [31:0] d);
    int k;
    logic r;
    k = 0;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(posedge hclk);
      r = hreadyout;
      d = hrdata;
      if (r === 1'b1 && hresp !== SCMD_HRESP_OKAY) begin
        fail("error response");
      end
      k++;
      tmo(k * 30);
    end
  endtask
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= SCMD_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    hwait(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait(d);
  endtask
  task wait_out(input int which, input int n);
    int k;
    k = 0;
    while (((which == 0) ? mq.size() : dq.size()) < n && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    tmo(k);
  endtask
  task cmp_out(input int which);
    int n;
    n = (which == 0) ? emq.size() : edq.size();
    chk((which == 0) ? mq.size() : dq.size(), n, "beat count");
    for (int k = 0; k < n; k++) begin
      chk((which == 0) ? mq[k] : dq[k], (which == 0) ? emq[k] : edq[k], "beat");
    end
    mq.delete();
    dq.delete();
    emq.delete();
    edq.delete();
  endtask
  function automatic logic [15:0] mbeat(int i, int k, logic eop);
    return {i[1] ^ k[1], k[0], 1'(k == 0), eop, 4'(i + k), 4'(i), 4'(k)};
  endfunction
  function automatic logic [17:0] mexp(int i, logic [15:0] b);
    return {b[15:12], 2'(i), b[11:0]};
  endfunction
  function automatic logic [15:0] dbeat(int c);
    return {c[2], c[0] ^ c[1], 1'(c == 0), 1'(c == 15), 4'(c), 8'hC0 ^ 8'(c)};
  endfunction
  function automatic logic [17:0] dexp(int c);
    logic [15:0] b;
    b = dbeat(c);
    return {2'h0, c[0], b[15:12], b[11:9], b[7:0]};
  endfunction
  // sources hold each beat until taken, then scramble idle data
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (mi_valid[i] && mi_ready[i]) begin
        void'(srcq[i].pop_front());
      end
      if (srcq[i].size() > 0) begin
        mi_valid[i] <= 1'b1;
        {mi_empty[i], mi_err[i], mi_sop[i], mi_eop[i], mi_ch[i*4+:4], mi_data[i*8+:8]} <= srcq[i][0];
      end else begin
        mi_valid[i] <= 1'b0;
        mi_data[i*8+:8] <= ~mi_data[i*8+:8];
      end
    end
    if (di_valid && di_ready) begin
      void'(dsrcq.pop_front());
    end
    if (dsrcq.size() > 0) begin
      di_valid <= 1'b1;
      {di_empty, di_err, di_sop, di_eop, di_ch, di_data} <= dsrcq[0];
    end else begin
      di_valid <= 1'b0;
      di_data <= ~di_data;
    end
    if (hresetn && mo_valid && mo_ready) begin
      mq.push_back({mo_empty, mo_err, mo_sop, mo_eop, mo_ch, mo_data});
    end
    if (hresetn && |(do_valid & do_ready)) begin
      dq.push_back({do_valid[1], do_empty, do_err, do_sop, do_eop, do_ch, do_data});
    end
    if (hresetn && $countones(mi_ready) > 1) begin
      fail("two inputs ready at once");
    end
    if (hresetn && $countones(do_valid) > 1) begin
      fail("two outputs valid at once");
    end
    // same grants in both builds, only the channel layout differs
    if (hresetn && (mi_ready2 !== mi_ready || mo_valid2 !== mo_valid)) begin
      fail("second build grants differ");
    end
    if (hresetn && mo_valid && {mo_ch2, mo_data2} !== {mo_ch[3:0], mo_ch[5:4], mo_data}) begin
      fail("source bits not at low end");
    end
    // data low nibble is the channel the source sent
    if (hresetn && |do_valid2) begin
      n_hi++;
      chk({do_valid2, do_ch2}, {do_data2[3] ? 2'h2 : 2'h1, do_data2[2:0]}, "high select");
    end
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, slow} = '0;
    {mi_valid, mi_data, mi_ch, mi_err, mi_sop, mi_eop, mi_empty} = '0;
    {di_valid, di_data, di_ch, di_err, di_sop, di_eop, di_empty} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, 32'(SCMD_CTRL_OFS), 32'h0, rd);
    chk(rd, 32'h3, "ctrl reset");
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    ahb(1'b1, 32'(SCMD_CTRL_OFS), 32'h0, rd);
    ahb(1'b0, 32'(SCMD_CTRL_OFS), 32'h0, rd);
    chk(rd, 32'h0, "ctrl written");
    ahb(1'b1, 32'(SCMD_CTRL_OFS), 32'h3, rd);
    $display("register test done");
    // grant lands on input 0 first, so the rotation start is known
    @(negedge hclk);
    srcq[0].push_back(mbeat(0, 0, 1'b0));
    emq.push_back(mexp(0, mbeat(0, 0, 1'b0)));
    wait_out(0, 1);
    @(negedge hclk);
    for (int i = 1; i <= 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        srcq[i % 4].push_back(mbeat(i % 4, k, 1'b0));
        emq.push_back(mexp(i % 4, mbeat(i % 4, k, 1'b0)));
      end
    end
    wait_out(0, 9);
    cmp_out(0);
    $display("round robin test done");
    slow <= 1'b1;
    @(negedge hclk);
    srcq[1].push_back(mbeat(1, 2, 1'b1));
    srcq[1].push_back(mbeat(1, 3, 1'b0));
    srcq[2].push_back(mbeat(2, 2, 1'b0));
    emq.push_back(mexp(1, mbeat(1, 2, 1'b1)));
    emq.push_back(mexp(2, mbeat(2, 2, 1'b0)));
    emq.push_back(mexp(1, mbeat(1, 3, 1'b0)));
    wait_out(0, 3);
    cmp_out(0);
    // last grant went to input 1, everything idle again
    ahb(1'b0, 32'(SCMD_STAT_OFS), 32'h0, rd);
    chk(rd, 32'h1 << SCMD_STAT_GRANT_LSB, "status after packets");
    $display("packet end test done");
    ahb(1'b1, 32'(SCMD_CTRL_OFS), 32'h1, rd);
    @(negedge hclk);
    dsrcq.push_back(dbeat(5));
    edq.push_back(dexp(5));
    repeat (10) @(posedge hclk);
    chk(dq.size(), 0, "demux held while off");
    ahb(1'b1, 32'(SCMD_CTRL_OFS), 32'h3, rd);
    @(negedge hclk);
    for (int c = 0; c < 16; c++) begin
      dsrcq.push_back(dbeat(c));
      edq.push_back(dexp(c));
    end
    wait_out(1, 17);
    cmp_out(1);
    chk(n_hi, 17, "high select beats");
    $display("demux test done");
    final_report();
  end
endmodule
`default_nettype wire
